// ### design/nvmc_defs.vh
// Constants for the nonvolatile byte access controller
`ifndef NVMC_DEFS_VH
`define NVMC_DEFS_VH

// Register indices, byte address is four times the index
`define NVMC_IDX_CTRL 8'h1C
`define NVMC_IDX_DATA 8'h1D
`define NVMC_IDX_ADDRL 8'h1E
`define NVMC_IDX_ADDRH 8'h1F

// Decoded register selects
`define NVMC_SEL_NONE 3'h0
`define NVMC_SEL_CTRL 3'h1
`define NVMC_SEL_DATA 3'h2
`define NVMC_SEL_ADDRL 3'h3
`define NVMC_SEL_ADDRH 3'h4

// Control register fields
`define NVMC_CTRL_READ 0
`define NVMC_CTRL_PROG 1
`define NVMC_CTRL_ARM 2
`define NVMC_CTRL_RIE 3
`define NVMC_CTRL_MODE_LO 4
`define NVMC_CTRL_MODE_HI 5

// Programming mode codes
`define NVMC_MODE_ATOMIC 2'h0
`define NVMC_MODE_ERASE 2'h1
`define NVMC_MODE_WRITE 2'h2
`define NVMC_MODE_RSVD 2'h3

// Reset values
`define NVMC_RST_MODE 2'h0
`define NVMC_RST_DATA 8'h00
`define NVMC_ERASED_BYTE 8'hFF

// Array geometry
`define NVMC_ADDR_W 9
`define NVMC_DEPTH 512

// CPU stall lengths and arm window in clock cycles
`define NVMC_READ_STALL 3'd4
`define NVMC_PROG_STALL 3'd2
`define NVMC_ARM_CYCLES 3'd4

// Programming times, timed by the oscillator tick
`define NVMC_ATOMIC_TIME_NS 3400000
`define NVMC_SPLIT_TIME_NS 1800000
`define NVMC_OSC_TICK_NS 1000
`define NVMC_ATOMIC_TICKS (`NVMC_ATOMIC_TIME_NS / `NVMC_OSC_TICK_NS)
`define NVMC_SPLIT_TICKS (`NVMC_SPLIT_TIME_NS / `NVMC_OSC_TICK_NS)
`define NVMC_TICK_W 12

`endif

// ### design/nvmc_array.v
// Byte array of the nonvolatile store with read and program ports
`include "nvmc_defs.vh"
`default_nettype none

module nvmc_array (
  input wire sys_clk,
  input wire ce,
  input wire [`NVMC_ADDR_W-1:0] rd_addr,
  output wire [7:0] rd_data,
  input wire prog_done,
  input wire [1:0] prog_mode,
  input wire [`NVMC_ADDR_W-1:0] prog_addr,
  input wire [7:0] prog_data
);

  reg [7:0] mem [0:`NVMC_DEPTH-1];

  // Any byte is read on its own
  assign rd_data = mem[rd_addr];

  // Cell update when the timed operation completes
  always @(posedge sys_clk)
  begin
    if (ce && prog_done)
    begin
      case (prog_mode)
        `NVMC_MODE_ATOMIC: mem[prog_addr] <= prog_data;
        `NVMC_MODE_ERASE: mem[prog_addr] <= `NVMC_ERASED_BYTE;
        `NVMC_MODE_WRITE: mem[prog_addr] <= mem[prog_addr] & prog_data;
        default: mem[prog_addr] <= mem[prog_addr];
      endcase
    end
  end

endmodule
`default_nettype wire

// ### design/nvmc_timer.v
// Programming duration timer counting calibrated oscillator ticks
`include "nvmc_defs.vh"
`default_nettype none

module nvmc_timer (
  input wire sys_clk,
  input wire por_n,
  input wire ce,
  input wire osc_tick,
  input wire start,
  input wire long_op,
  output wire busy,
  output wire done
);

  reg [`NVMC_TICK_W-1:0] ticks;
  wire [31:0] atomic_load;
  wire [31:0] split_load;

  // Durations as plain integers, cut to the counter width where loaded
  assign atomic_load = `NVMC_ATOMIC_TICKS;
  assign split_load = `NVMC_SPLIT_TICKS;

  // Busy while ticks remain, survives system reset
  assign busy = (ticks != {`NVMC_TICK_W{1'b0}});
  assign done = ce & osc_tick & (ticks == {{(`NVMC_TICK_W-1){1'b0}}, 1'b1});

  // Load the duration and count down on oscillator ticks
  always @(posedge sys_clk or negedge por_n)
  begin
    if (!por_n)
      ticks <= {`NVMC_TICK_W{1'b0}};
    else if (ce)
    begin
      if (start && !busy)
        ticks <= long_op ? atomic_load[`NVMC_TICK_W-1:0]
          : split_load[`NVMC_TICK_W-1:0];
      else if (busy && osc_tick)
        ticks <= ticks - {{(`NVMC_TICK_W-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

// ### design/nvmc_top.v
// Nonvolatile byte memory access controller with AHB-Lite register slave
`include "nvmc_defs.vh"
`default_nettype none

// How it works
// - A 512-byte array is its own space and each byte is read or written alone.
// - Address, data and control registers sit at word slots on the register bus.
// - A read strobe stretches the bus data phase by four cycles.
// - A program start stretches the bus data phase by two cycles.
// - Mode zero with strobe inside the arm window erases and writes the byte.
// - The program strobe reads set for the whole operation and clears at its end.
// - No read or program is started while programming runs.
// - Mode one with strobe inside the arm window erases the addressed byte only.
// - Mode two with strobe inside the arm window writes the byte without erase.
// - Programming time is counted on the calibrated oscillator tick.
// - A read strobe copies the addressed byte into the data register.
// - Combined takes 3.4 ms, split modes 1.8 ms, mode three is reserved.
// - Mode writes are ignored while busy and reset clears mode unless busy.
// - The ready interrupt is high while enabled, globally enabled and idle.
module nvmc_top (
  input wire sys_clk,
  input wire rst_n,
  input wire por_n,
  input wire ce,
  input wire osc_tick,
  input wire global_irq_enable,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg nvm_ready_irq,
  output reg nvm_busy
);

  // Word address to register select
  function [2:0] nvmc_decode;
    input [31:0] a;
    begin
      if (a[1:0] != 2'h0 || a[31:10] != 22'h0)
        nvmc_decode = `NVMC_SEL_NONE;
      else if (a[9:2] == `NVMC_IDX_CTRL)
        nvmc_decode = `NVMC_SEL_CTRL;
      else if (a[9:2] == `NVMC_IDX_DATA)
        nvmc_decode = `NVMC_SEL_DATA;
      else if (a[9:2] == `NVMC_IDX_ADDRL)
        nvmc_decode = `NVMC_SEL_ADDRL;
      else if (a[9:2] == `NVMC_IDX_ADDRH)
        nvmc_decode = `NVMC_SEL_ADDRH;
      else
        nvmc_decode = `NVMC_SEL_NONE;
    end
  endfunction

  reg dp_active;
  reg dp_write;
  reg dp_exec;
  reg [2:0] dp_sel;
  reg [2:0] wait_cnt;
  reg [2:0] arm_cnt;
  reg [1:0] nvm_prog_mode_field;
  reg nvm_ready_irq_enable;
  reg [`NVMC_ADDR_W-1:0] nvm_byte_address_reg;
  reg [7:0] nvm_byte_data_reg;
  reg [1:0] op_mode;
  reg [`NVMC_ADDR_W-1:0] op_addr;
  reg [7:0] op_data;
  wire prog_busy;
  wire prog_done;
  wire [7:0] array_byte;
  wire exec;
  wire ctrl_wr;
  wire armed;
  wire start_now;
  wire read_now;
  wire mode_we;
  wire [7:0] ctrl_view;

  // Data phase work happens once, in its first low-ready cycle
  assign exec = dp_active & ~hreadyout & ~dp_exec;
  assign ctrl_wr = exec & dp_write & (dp_sel == `NVMC_SEL_CTRL);
  assign armed = (arm_cnt != 3'd0);
  assign start_now = ctrl_wr & hwdata[`NVMC_CTRL_PROG] & armed & ~prog_busy
    & (nvm_prog_mode_field != `NVMC_MODE_RSVD);
  assign read_now = ctrl_wr & hwdata[`NVMC_CTRL_READ] & ~prog_busy & ~start_now;
  assign mode_we = ce & ctrl_wr & ~prog_busy;
  assign ctrl_view = {2'b00, nvm_prog_mode_field, nvm_ready_irq_enable, armed,
    prog_busy, 1'b0};

  // Timed programming engine
  nvmc_timer u_timer (
    .sys_clk(sys_clk),
    .por_n(por_n),
    .ce(ce),
    .osc_tick(osc_tick),
    .start(start_now),
    .long_op(nvm_prog_mode_field == `NVMC_MODE_ATOMIC),
    .busy(prog_busy),
    .done(prog_done)
  );

  // Storage cells
  nvmc_array u_array (
    .sys_clk(sys_clk),
    .ce(ce),
    .rd_addr(nvm_byte_address_reg),
    .rd_data(array_byte),
    .prog_done(prog_done),
    .prog_mode(op_mode),
    .prog_addr(op_addr),
    .prog_data(op_data)
  );

  // Mode field kept across system reset while programming runs
  always @(posedge sys_clk or negedge por_n)
  begin
    if (!por_n)
      nvm_prog_mode_field <= `NVMC_RST_MODE;
    else if (ce)
    begin
      if (!rst_n && !prog_busy)
        nvm_prog_mode_field <= `NVMC_RST_MODE;
      else if (rst_n && mode_we)
        nvm_prog_mode_field <= hwdata[`NVMC_CTRL_MODE_HI:`NVMC_CTRL_MODE_LO];
    end
  end

  // Operation snapshot taken at program start, kept through system reset
  // so that a running operation still ends at its own cell
  always @(posedge sys_clk or negedge por_n)
  begin
    if (!por_n)
    begin
      op_mode <= `NVMC_RST_MODE;
      op_addr <= {`NVMC_ADDR_W{1'b0}};
      op_data <= `NVMC_RST_DATA;
    end
    else if (ce && start_now)
    begin
      op_mode <= nvm_prog_mode_field;
      op_addr <= nvm_byte_address_reg;
      op_data <= nvm_byte_data_reg;
    end
  end

  // Busy copy follows the timer, which runs on through system reset
  always @(posedge sys_clk or negedge por_n)
  begin
    if (!por_n)
      nvm_busy <= 1'b0;
    else if (ce)
      nvm_busy <= prog_busy;
  end

  // Bus slave, registers and stall control
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_active <= 1'b0;
      dp_write <= 1'b0;
      dp_exec <= 1'b0;
      dp_sel <= `NVMC_SEL_NONE;
      wait_cnt <= 3'd0;
      arm_cnt <= 3'd0;
      nvm_ready_irq_enable <= 1'b0;
      nvm_byte_address_reg <= {`NVMC_ADDR_W{1'b0}};
      nvm_byte_data_reg <= `NVMC_RST_DATA;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      nvm_ready_irq <= 1'b0;
    end
    else if (ce)
    begin
      nvm_ready_irq <= nvm_ready_irq_enable & global_irq_enable & ~prog_busy;
      // Arm window runs down by itself
      if (armed)
        arm_cnt <= arm_cnt - 3'd1;
      if (hready && hsel && htrans[1])
      begin
        dp_active <= 1'b1;
        dp_write <= hwrite;
        dp_exec <= 1'b0;
        dp_sel <= nvmc_decode(haddr);
        hreadyout <= 1'b0;
      end
      else if (exec)
      begin
        dp_exec <= 1'b1;
        wait_cnt <= 3'd0;
        hreadyout <= 1'b1;
        if (!dp_write)
        begin
          case (dp_sel)
            `NVMC_SEL_CTRL: hrdata <= {24'h000000, ctrl_view};
            `NVMC_SEL_DATA: hrdata <= {24'h000000, nvm_byte_data_reg};
            `NVMC_SEL_ADDRL: hrdata <= {24'h000000, nvm_byte_address_reg[7:0]};
            `NVMC_SEL_ADDRH: hrdata <= {31'h0, nvm_byte_address_reg[8]};
            default: hrdata <= 32'h0000_0000;
          endcase
        end
        else
        begin
          case (dp_sel)
            `NVMC_SEL_CTRL:
            begin
              nvm_ready_irq_enable <= hwdata[`NVMC_CTRL_RIE];
              if (start_now)
              begin
                arm_cnt <= 3'd0;
                wait_cnt <= `NVMC_PROG_STALL;
                hreadyout <= 1'b0;
              end
              else if (hwdata[`NVMC_CTRL_ARM])
                arm_cnt <= `NVMC_ARM_CYCLES;
              if (read_now)
              begin
                nvm_byte_data_reg <= array_byte;
                wait_cnt <= `NVMC_READ_STALL;
                hreadyout <= 1'b0;
              end
            end
            `NVMC_SEL_DATA: nvm_byte_data_reg <= hwdata[7:0];
            `NVMC_SEL_ADDRL: nvm_byte_address_reg[7:0] <= hwdata[7:0];
            `NVMC_SEL_ADDRH: nvm_byte_address_reg[8] <= hwdata[0];
            default: dp_sel <= `NVMC_SEL_NONE;
          endcase
        end
      end
      else if (dp_active && !hreadyout)
      begin
        // Stall cycles before the data phase may end
        if (wait_cnt <= 3'd1)
          hreadyout <= 1'b1;
        wait_cnt <= wait_cnt - 3'd1;
      end
      else if (dp_active && hreadyout)
        dp_active <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### verif/nvmc_sva.sv
// Port checks for the nonvolatile access controller
`default_nettype none
module nvmc_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic osc_tick,
  input wire logic global_irq_enable,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic nvm_ready_irq,
  input wire logic nvm_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic ctrl_wr;
  logic [11:0] tick_cnt;
  // First data cycle of a control write, and ticks seen while busy
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_wr <= 1'b0;
    else
      ctrl_wr <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h70;
  end
  // Tick count runs on through system reset, as programming does
  always_ff @(posedge sys_clk or negedge por_n)
  begin
    if (!por_n)
      tick_cnt <= 12'h000;
    else
      tick_cnt <= !nvm_busy ? 12'h000 : tick_cnt + {11'h000, osc_tick};
  end
  sequence rd_start;
    ctrl_wr && hwdata[1:0] == 2'h1 && !nvm_busy;
  endsequence
  sequence prog_start;
    $rose(nvm_busy);
  endsequence
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response");
  read_stall_a: assert property (rd_start |-> !hreadyout [*5] ##1 hreadyout)
    else $error("read stall length wrong");
  prog_stall_a: assert property (prog_start |-> !hreadyout ##1 hreadyout)
    else $error("program stall length wrong");
  busy_quiet_a: assert property (ctrl_wr && nvm_busy |=> hreadyout)
    else $error("stall while busy");
  irq_idle_a: assert property (nvm_ready_irq |-> !nvm_busy && $past(global_irq_enable))
    else $error("ready irq while busy");
  data_hold_a: assert property (!$stable(hrdata) |-> hreadyout)
    else $error("read data moved early");
  ready_bound_a: assert property (!hreadyout |-> ##[1:5] hreadyout)
    else $error("data phase too long");
  busy_len_a: assert property ($fell(nvm_busy) |-> (tick_cnt > 12'd1797 && tick_cnt < 12'd1803)
    || (tick_cnt > 12'd3397 && tick_cnt < 12'd3403))
    else $error("program time wrong");
endmodule
bind nvmc_top nvmc_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n),
  .osc_tick(osc_tick),
  .global_irq_enable(global_irq_enable), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .nvm_ready_irq(nvm_ready_irq), .nvm_busy(nvm_busy));
`default_nettype wire

// ### verif/nvmc_osc_model.sv
// Calibrated oscillator tick source for the programming timer
`default_nettype none
module nvmc_osc_model #(
  parameter int DIV = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic osc_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // One tick every DIV clocks, independent of bus traffic
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      osc_tick <= 1'b0;
    end
    else
    begin
      cnt <= (cnt >= DIV - 1) ? 0 : cnt + 1;
      osc_tick <= (cnt >= DIV - 1);
    end
  end
endmodule
`default_nettype wire

// ### verif/nvmc_top_tb.sv
// Self-checking bench for the nonvolatile access controller
`default_nettype none
module nvmc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic global_irq_enable = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q = 32'h0;
  logic [1:0] htrans = 2'h0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, nvm_ready_irq, nvm_busy, osc_tick;
  int errors = 0;
  int compares = 0;
  nvmc_osc_model #(.DIV(1)) osc_model (.sys_clk(sys_clk), .rst_n(por_n), .osc_tick(osc_tick));
  nvmc_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .ce(1'b1),
    .osc_tick(osc_tick), .global_irq_enable(global_irq_enable), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .nvm_ready_irq(nvm_ready_irq),
    .nvm_busy(nvm_busy));
  // Clock of 20 ns period
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask
  // One single bus transfer, read data left in q
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    q = hrdata;
  endtask
  task rd_byte(input logic [8:0] a, input logic [7:0] exp);
    xfer(8'h78, 1'b1, {24'h0, a[7:0]});
    xfer(8'h7C, 1'b1, {31'h0, a[8]});
    xfer(8'h70, 1'b1, 32'h9);
    xfer(8'h74, 1'b0, 32'h0);
    chk(q, {24'h0, exp});
  endtask
  // Arm then strobe, refused accesses while busy, then wait for the strobe to clear
  task prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
    xfer(8'h70, 1'b1, {26'h0, m, 4'h8});
    xfer(8'h78, 1'b1, {24'h0, a[7:0]});
    xfer(8'h7C, 1'b1, {31'h0, a[8]});
    xfer(8'h74, 1'b1, {24'h0, d});
    xfer(8'h70, 1'b1, {26'h0, m, 4'hC});
    xfer(8'h70, 1'b1, {26'h0, m, 4'hA});
    chk({31'h0, nvm_ready_irq}, 32'h0);
    xfer(8'h70, 1'b1, 32'h39);
    xfer(8'h70, 1'b0, 32'h0);
    chk(q, {26'h0, m, 4'hA});
    q = 32'h2;
    while (q[1] === 1'b1) xfer(8'h70, 1'b0, 32'h0);
    @(posedge sys_clk);
    chk({31'h0, nvm_ready_irq}, 32'h1);
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    xfer(8'h74, 1'b0, 32'h0);
    chk(q, 32'h0);
    xfer(8'h70, 1'b0, 32'h0);
    chk(q, 32'h0);
    xfer(8'h78, 1'b1, 32'hA5);
    xfer(8'h78, 1'b0, 32'h0);
    chk(q, 32'hA5);
    xfer(8'h40, 1'b1, 32'h5A);
    xfer(8'h40, 1'b0, 32'h0);
    chk(q, 32'h0);
    $display("test registers done");
    xfer(8'h70, 1'b1, 32'h0C);
    repeat (5) @(posedge sys_clk);
    xfer(8'h70, 1'b1, 32'h0A);
    chk({31'h0, nvm_busy}, 32'h0);
    xfer(8'h70, 1'b1, 32'h3C);
    xfer(8'h70, 1'b1, 32'h3A);
    xfer(8'h70, 1'b0, 32'h0);
    chk(q & 32'h3A, 32'h38);
    $display("test refusals done");
    prog(2'h1, 9'h1A5, 8'h00);
    rd_byte(9'h1A5, 8'hFF);
    prog(2'h2, 9'h1A5, 8'h3C);
    rd_byte(9'h1A5, 8'h3C);
    prog(2'h0, 9'h0FF, 8'h5A);
    rd_byte(9'h0FF, 8'h5A);
    rd_byte(9'h1A5, 8'h3C);
    $display("test programming done");
    // Ready interrupt drops with the global enable
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, nvm_ready_irq}, 32'h0);
    global_irq_enable <= 1'b1;
    // System reset in mid-erase keeps mode and busy, an idle one clears mode
    xfer(8'h70, 1'b1, 32'h14);
    xfer(8'h70, 1'b1, 32'h12);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk({31'h0, nvm_busy}, 32'h1);
    xfer(8'h70, 1'b0, 32'h0);
    chk(q, 32'h12);
    q = 32'h2;
    while (q[1] === 1'b1) xfer(8'h70, 1'b0, 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    xfer(8'h70, 1'b0, 32'h0);
    chk(q, 32'h0);
    rd_byte(9'h1A5, 8'hFF);
    $display("test resets done");
    stop_test;
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    stop_test;
  end
  task stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
endmodule
`default_nettype wire
